// ===== design/flash_guard_host.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "flash_guard_consts.svh"

// Summary of operation
// - After an abort the host sets the abort status flag and drops the pending operation; it does not repeat the command sequence.
// - After an erase or program operation ends while powered up, the host sets need_ra_q until a Read Array command is written or power is dropped.
// - Writes need both enables low; the host keeps one high whenever not writing.
// - After raising power-down the host rejects commands with the error flag until the write wake-up delay has passed; reads are not held back.
module flash_guard_host
	import flash_guard_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic [3:0]           addr,
	input  wire logic [15:0]          wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic      [15:0]          rdata,
	input  wire logic                 busy_in,
	input  wire logic [15:0]          fdq_in,
	output logic      [15:0]          fdq_out,
	output logic                      fdq_oe_n,
	output logic                      ce_n,
	output logic                      we_n,
	output logic                      oe_n,
	output logic                      reset_powerdown_n
);
	import flash_guard_pkg::*;

	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	logic       rs1_q;
	logic       rst_n;
	logic       bs1_q;
	logic       bs2_q;

	// Release reset through two flip-flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end

	// Busy pin sampled at all times; float reads high through pull-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bs1_q <= 1'b1;
			bs2_q <= 1'b1;
		end else begin
			bs1_q <= busy_in;
			bs2_q <= bs1_q;
		end
	end

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	phase_t      ph_q, ph_d;
	logic        pwr_q, pwr_d;
	logic        pend_q, pend_d;
	logic        started_q, started_d;
	logic        abort_q, abort_d;
	logic        err_q, err_d;
	logic        need_ra_q, need_ra_d;
	logic [3:0]  cnt_q, cnt_d;
	word_t       cmd_q, cmd_d;
	word_t       cmd_in_q, cmd_in_d;
	logic        cmd_v_q, cmd_v_d;
	logic        ce_n_q, ce_n_d;
	logic        we_n_q, we_n_d;
	logic        dq_oe_n_q, dq_oe_n_d;
	logic [15:0] rdata_q, rdata_d;
	logic        read_ok;
	logic        write_ok;
	logic        busy;

	assign busy = !bs2_q;

	// Wake-up interval counter
	wake_timer u_wake (
		.clk      (clk),
		.rst_n    (rst_n),
		.awake    (pwr_q),
		.read_ok  (read_ok),
		.write_ok (write_ok)
	);

	// Commands that start an array operation
	function automatic logic is_setup(input word_t c);
		is_setup = (c == `CMD_ERASE_SETUP) || (c == `CMD_PROG_SETUP);
	endfunction : is_setup

	// Commands allowed while the flash reports busy
	function automatic logic busy_safe(input word_t c);
		busy_safe = (c == `CMD_READ_STATUS) || (c == `CMD_SUSPEND);
	endfunction : busy_safe

	// Next state of bus, write engine and status
	always_comb begin
		ph_d      = ph_q;
		pwr_d     = pwr_q;
		pend_d    = pend_q;
		started_d = started_q;
		abort_d   = abort_q;
		err_d     = err_q;
		need_ra_d = need_ra_q;
		cnt_d     = cnt_q;
		cmd_d     = cmd_q;
		cmd_in_d  = cmd_in_q;
		cmd_v_d   = cmd_v_q;
		ce_n_d    = 1'b1;
		we_n_d    = 1'b1;
		dq_oe_n_d = 1'b1;
		rdata_d   = 16'h0000;

		// Register writes
		if (wr) begin
			if (addr == `REG_CTRL) begin
				pwr_d = wdata[`CTRL_PWR_BIT];
				if (!wdata[`CTRL_PWR_BIT] && (pend_q || busy)) begin
					abort_d = 1'b1;
					pend_d  = 1'b0;
				end
			end else if (addr == `REG_CMD) begin
				cmd_in_d = wdata;
				cmd_v_d  = 1'b1;
			end else if (addr == `REG_STATUS) begin
				abort_d = abort_q & ~wdata[`ST_ABORT_BIT];
				err_d   = err_q & ~wdata[`ST_ERR_BIT];
			end
		end

		// Launch a queued command when allowed
		if (ph_q == PH_IDLE && cmd_v_q) begin
			cmd_v_d = wr && (addr == `REG_CMD); // Keep a command written in this cycle
			if (!pwr_q || !write_ok) begin
				err_d = 1'b1;
			end else if (busy && !busy_safe(cmd_in_q)) begin
				err_d = 1'b1;
			end else begin
				cmd_d = cmd_in_q;
				cnt_d = 4'(`WE_PULSE_CYC);
				ph_d  = PH_SETUP;
				if (is_setup(cmd_q) || pend_q)
					pend_d = 1'b1;
				if (cmd_in_q == `CMD_READ_ARRAY)
					need_ra_d = 1'b0;
			end
		end

		// Write strobe: ce low first, then we pulse, then release
		case (ph_q)
			PH_SETUP: begin
				ce_n_d    = 1'b0;
				dq_oe_n_d = 1'b0;
				ph_d      = PH_PULSE;
			end
			PH_PULSE: begin
				ce_n_d   = 1'b0;
				we_n_d    = 1'b0;
				dq_oe_n_d = 1'b0;
				cnt_d    = cnt_q - 4'h1;
				if (cnt_q == 4'h1)
					ph_d = PH_HOLD;
			end
			PH_HOLD: begin
				ph_d = PH_IDLE;
			end
			default: begin
			end
		endcase

		// Operation tracking from the busy pin
		if (pend_q && busy)
			started_d = 1'b1;
		if (started_q && !busy) begin
			started_d = 1'b0;
			pend_d    = 1'b0;
			need_ra_d = 1'b1;
		end
		if (!pwr_q)
			need_ra_d = 1'b0;

		// Register reads, data one cycle later
		if (rd) begin
			if (addr == `REG_CTRL)
				rdata_d = {15'h0000, pwr_q};
			else if (addr == `REG_CMD)
				rdata_d = cmd_q;
			else if (addr == `REG_STATUS)
				rdata_d = {6'h00, err_q, read_ok, write_ok, ph_q,
					abort_q, need_ra_q, busy};
			else if (addr == `REG_RDATA)
				rdata_d = fdq_in;
		end
	end

	// Registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q      <= PH_IDLE;
			pwr_q     <= 1'b0;
			pend_q    <= 1'b0;
			started_q <= 1'b0;
			abort_q   <= 1'b0;
			err_q     <= 1'b0;
			need_ra_q <= 1'b0;
			cnt_q     <= 4'h0;
			cmd_q     <= 16'h0000;
			cmd_in_q  <= 16'h0000;
			cmd_v_q   <= 1'b0;
			ce_n_q    <= 1'b1;
			we_n_q    <= 1'b1;
			dq_oe_n_q <= 1'b1;
			rdata_q   <= 16'h0000;
		end else begin
			ph_q      <= ph_d;
			pwr_q     <= pwr_d;
			pend_q    <= pend_d;
			started_q <= started_d;
			abort_q   <= abort_d;
			err_q     <= err_d;
			need_ra_q <= need_ra_d;
			cnt_q     <= cnt_d;
			cmd_q     <= cmd_d;
			cmd_in_q  <= cmd_in_d;
			cmd_v_q   <= cmd_v_d;
			ce_n_q    <= ce_n_d;
			we_n_q    <= we_n_d;
			dq_oe_n_q <= dq_oe_n_d;
			rdata_q   <= rdata_d;
		end
	end

	assign rdata             = rdata_q;
	assign ce_n              = ce_n_q;
	assign we_n              = we_n_q;
	assign oe_n              = 1'b1;
	assign fdq_out           = cmd_q;
	assign fdq_oe_n          = dq_oe_n_q;
	assign reset_powerdown_n = pwr_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_pulse;
		!we_n && !ce_n;
	endsequence

	property p_we_needs_ce;
		@(posedge clk) disable iff (!rst_n) !we_n |-> !ce_n;
	endproperty
	a_we_needs_ce: assert property (p_we_needs_ce) else $error("we low without ce");

	property p_no_write_asleep;
		@(posedge clk) disable iff (!rst_n) !reset_powerdown_n |-> we_n;
	endproperty
	a_no_write_asleep: assert property (p_no_write_asleep) else $error("write while down");

	property p_wake_wait;
		@(posedge clk) disable iff (!rst_n) s_pulse |-> write_ok;
	endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("write before wake");

	property p_drive_with_we;
		@(posedge clk) disable iff (!rst_n) !we_n |-> !fdq_oe_n;
	endproperty
	a_drive_with_we: assert property (p_drive_with_we) else $error("data not driven");

	// Cycles the write strobe has been low so far, for the pulse checks
	logic [4:0] we_low_q;
	logic [4:0] we_low_d;

	assign we_low_d = we_n ? 5'h00 : we_low_q + 5'h01;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			we_low_q <= 5'h00;
		else
			we_low_q <= we_low_d;
	end

	property p_pulse_len;
		@(posedge clk) disable iff (!rst_n) $rose(we_n) |-> we_low_q == 5'(`WE_PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("we pulse length");

	property p_pulse_max;
		@(posedge clk) disable iff (!rst_n) !we_n |-> we_low_q < 5'(`WE_PULSE_CYC);
	endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("we pulse too long");

	property p_abort_flag;
		@(posedge clk) disable iff (!rst_n)
			(wr && addr == `REG_CTRL && !wdata[0] && pend_q) |=> abort_q;
	endproperty
	a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged");

	property p_ra_after_op;
		@(posedge clk) disable iff (!rst_n) (started_q && !busy && pwr_q) |=> need_ra_q;
	endproperty
	a_ra_after_op: assert property (p_ra_after_op) else $error("read array not required");

	property p_busy_cmds;
		@(posedge clk) disable iff (!rst_n)
			(ph_q == PH_IDLE && cmd_v_q && busy && !busy_safe(cmd_in_q)) |=> ph_q == PH_IDLE;
	endproperty
	a_busy_cmds: assert property (p_busy_cmds) else $error("command while busy");

endmodule : flash_guard_host

// ===== design/flash_guard_consts.svh
`ifndef FLASH_GUARD_CONSTS_SVH
`define FLASH_GUARD_CONSTS_SVH

// ----------------------------------------
// Register offsets of the controller
// ----------------------------------------
`define REG_CTRL        4'h0
`define REG_CMD         4'h1
`define REG_STATUS      4'h2
`define REG_RDATA       4'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_PWR_BIT    0
`define ST_BUSY_BIT     0
`define ST_READY_BIT    1
`define ST_ABORT_BIT    2
`define ST_PHASE_LSB    3
`define ST_AWAKE_BIT    7
`define ST_READ_OK_BIT  8
`define ST_ERR_BIT      9

// ----------------------------------------
// Flash command codes
// ----------------------------------------
`define CMD_READ_ARRAY  16'h00FF
`define CMD_READ_STATUS 16'h0070
`define CMD_ERASE_SETUP 16'h0020
`define CMD_CONFIRM     16'h00D0
`define CMD_PROG_SETUP  16'h0040
`define CMD_SUSPEND     16'h00B0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS   4
`define WAKE_READ_NS    600
`define WAKE_WRITE_NS   1000
`define WE_PULSE_NS     50
`define WAKE_READ_CYC   ((`WAKE_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_WRITE_CYC  ((`WAKE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_PULSE_CYC    ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== design/flash_guard_pkg.sv
package flash_guard_pkg;

	// Bus cycle phases of the write strobe engine
	typedef enum logic [3:0] {
		PH_IDLE  = 4'b0001,
		PH_SETUP = 4'b0010,
		PH_PULSE = 4'b0100,
		PH_HOLD  = 4'b1000
	} phase_t;

	typedef logic [15:0] word_t;

endpackage : flash_guard_pkg

// ===== design/wake_timer.sv
`timescale 1ns/1ps
`include "flash_guard_consts.svh"

// Counts wake-up intervals after the flash power-down pin is raised
module wake_timer (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic awake,
	output logic      read_ok,
	output logic      write_ok
);

	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic       rd_q;
	logic       rd_d;
	logic       wr_q;
	logic       wr_d;

	// Restart on power-down, count up while awake until write_ok is set, then hold
	always_comb begin
		cnt_d = cnt_q;
		rd_d  = rd_q;
		wr_d  = wr_q;
		if (!awake) begin
			cnt_d = 10'h000;
			rd_d  = 1'b0;
			wr_d  = 1'b0;
		end else begin
			if (!wr_q)
				cnt_d = cnt_q + 10'h001;
			if (cnt_q >= 10'(`WAKE_READ_CYC))
				rd_d = 1'b1;
			if (cnt_q >= 10'(`WAKE_WRITE_CYC))
				wr_d = 1'b1;
		end
	end

	// Registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 10'h000;
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rd_q  <= rd_d;
			wr_q  <= wr_d;
		end
	end

	assign read_ok  = rd_q;
	assign write_ok = wr_q;

endmodule : wake_timer

// ===== sim/flash_dev_model.sv
`timescale 1ns/1ps

// Behavioural flash on the far side of the controller
module flash_dev_model
	import flash_guard_pkg::*;
#(
	parameter int BUSY_CYC = 40
)(
	input  wire logic  clk,
	input  wire logic  ce_n,
	input  wire logic  we_n,
	input  wire logic  rp_n,
	input  wire word_t dq,
	input  wire logic  supply_low,
	output logic       pull_low,
	output word_t      last_cmd,
	output word_t      status
);
	logic  erase_q = 1'b0;
	logic  we_q    = 1'b1;
	logic  ce_q    = 1'b1;
	logic  setup_q = 1'b0;
	logic  susp_q  = 1'b0;
	word_t dq_q    = 16'h0000;
	int    cnt     = 0;

	// Open-drain pin: low while the algorithm runs, floats when suspended
	assign pull_low = (cnt > 0) && !susp_q;

	// Command latch taken on the rising write strobe
	always @(posedge clk) begin
		we_q <= we_n;
		ce_q <= ce_n;
		dq_q <= dq;
		if (!rp_n) begin
			setup_q  <= 1'b0;
			susp_q   <= 1'b0;
			last_cmd <= 16'h00FF;
			status   <= 16'h0000;
			cnt      <= (cnt > 8) ? 7 : ((cnt > 0) ? cnt - 1 : 0);
		end else begin
			if (cnt > 0)
				cnt <= cnt - 1;
			if (!we_q && !ce_q && we_n) begin
				last_cmd <= dq_q;
				if (cnt > 0) begin
					if (dq_q == 16'h00B0)
						susp_q <= 1'b1;
				end else if (setup_q) begin
					setup_q <= 1'b0;
					if (supply_low)
						status <= erase_q ? 16'h0028 : 16'h0018;
					else
						cnt <= BUSY_CYC;
				end else if (dq_q == 16'h0020 || dq_q == 16'h0040) begin
					setup_q <= 1'b1;
					erase_q <= (dq_q == 16'h0020);
				end
			end
		end
	end
endmodule : flash_dev_model

// ===== sim/flash_guard_host_tb_top.sv
`timescale 1ns/1ps
`include "flash_guard_consts.svh"

// Bench for the flash write-guard controller
module flash_guard_host_tb_top;
	import flash_guard_pkg::*;
	logic       clk;
	logic       nrst;
	logic [3:0] addr;
	word_t      wdata;
	logic       wr;
	logic       rd;
	word_t      rdata;
	word_t      fdq_out;
	logic       fdq_oe_n;
	logic       ce_n;
	logic       we_n;
	logic       oe_n;
	logic       rp_n;
	logic       pull_low;
	word_t      last_cmd;
	word_t      fstat;
	logic       supply_low;
	word_t      rv;
	int         n_errors = 0;
	int         checks = 0;
	int         cyc = 0;
	int         we_run = 0;
	int         we_len = 0;
	int         bad_we = 0;

	flash_guard_host flash_guard_host_inst (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy_in(!pull_low),
		.fdq_in(~fdq_out), .fdq_out(fdq_out), .fdq_oe_n(fdq_oe_n), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .reset_powerdown_n(rp_n));
	flash_dev_model flash_dev_model_inst (.clk(clk), .ce_n(ce_n), .we_n(we_n),
		.rp_n(rp_n), .dq(fdq_out), .supply_low(supply_low), .pull_low(pull_low),
		.last_cmd(last_cmd), .status(fstat));

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog and write strobe monitor
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
		if (!we_n)
			we_run <= we_run + 1;
		else if (we_run != 0) begin
			we_len <= we_run;
			we_run <= 0;
		end
		if ((!we_n && (ce_n || fdq_oe_n)) || (!oe_n && !fdq_oe_n))
			bad_we <= bad_we + 1;
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr_reg(input logic [3:0] a, input word_t d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output word_t d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic cmp(input word_t got, input word_t exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wait_pin(input logic lvl);
		int i;
		for (i = 0; i < 2000 && pull_low === lvl; i++)
			@(posedge clk);
		cmp(word_t'(pull_low), word_t'(!lvl));
		repeat (4) @(posedge clk);
	endtask : wait_pin

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		supply_low = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		cmp(word_t'(rp_n), 16'h0000);
		wr_reg(`REG_CMD, `CMD_ERASE_SETUP);
		cmp(word_t'(ce_n), 16'h0001);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[`ST_ERR_BIT]), 16'h0001);
		wr_reg(`REG_STATUS, 16'h0200);
		rd_reg(4'hF, rv);
		cmp(rv, 16'h0000);
		$display("test powered-down done");
		wr_reg(`REG_CTRL, 16'h0001);
		wr_reg(`REG_CMD, `CMD_ERASE_SETUP);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[`ST_ERR_BIT]), 16'h0001);
		wr_reg(`REG_STATUS, 16'h0200);
		repeat (`WAKE_WRITE_CYC + 4) @(posedge clk);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[`ST_READ_OK_BIT]), 16'h0001);
		cmp(word_t'(rv[`ST_ERR_BIT]), 16'h0000);
		$display("test wake done");
		wr_reg(`REG_CMD, `CMD_ERASE_SETUP);
		wr_reg(`REG_CMD, `CMD_CONFIRM);
		wait_pin(1'b0);
		cmp(word_t'(we_len), 16'(`WE_PULSE_CYC));
		cmp(last_cmd, `CMD_CONFIRM);
		rd_reg(`REG_RDATA, rv);
		cmp(rv, 16'hFF2F);
		wr_reg(`REG_CMD, `CMD_PROG_SETUP);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[`ST_ERR_BIT]), 16'h0001);
		wr_reg(`REG_STATUS, 16'h0200);
		wait_pin(1'b1);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[1]), 16'h0001);
		wr_reg(`REG_CMD, `CMD_READ_ARRAY);
		repeat (30) @(posedge clk);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[1]), 16'h0000);
		$display("test erase done");
		supply_low <= 1'b1;
		wr_reg(`REG_CMD, `CMD_ERASE_SETUP);
		wr_reg(`REG_CMD, `CMD_CONFIRM);
		repeat (50) @(posedge clk);
		cmp(fstat, 16'h0028);
		cmp(word_t'(pull_low), 16'h0000);
		supply_low <= 1'b0;
		$display("test supply fault done");
		wr_reg(`REG_CMD, `CMD_PROG_SETUP);
		wr_reg(`REG_CMD, 16'h1234);
		wait_pin(1'b0);
		wr_reg(`REG_CTRL, 16'h0000);
		repeat (2) @(posedge clk);
		cmp(word_t'(pull_low), 16'h0001);
		rd_reg(`REG_STATUS, rv);
		cmp(word_t'(rv[`ST_ABORT_BIT]), 16'h0001);
		wait_pin(1'b1);
		cmp(last_cmd, `CMD_READ_ARRAY);
		cmp(word_t'(bad_we), 16'h0000);
		cmp(fstat, 16'h0000);
		cmp(word_t'(fdq_oe_n), 16'h0001);
		$display("test abort done");
		give_verdict();
	end
endmodule : flash_guard_host_tb_top
